// ===== hdl/fdcrb_bank.sv
// Purpose: Floppy resource and pin trigger configuration bank, Avalon-MM slave
// Assumes: One clock, synchronous active-low reset, pins asynchronous
// Notes:   Every access answers with one wait cycle
//
// Behaviour
// - Pin control bit 4 set bypasses general_pin_25 debounce filter.
// - Pin control bit 6 set bypasses general_pin_27 debounce filter.
// - Pin control bit 2 selects level (1) or edge (0) for pin 27.
// - Pin control bit 1 selects level (1) or edge (0) for pin 26.
// - Pin control bit 0 selects level (1) or edge (0) for pin 25.
// - Two test-mode bytes are plain storage resetting to zero; software keeps zero.
// - Activation bit 0 enables floppy_controller; resets to one.
// - Base high/low hold 8-byte aligned I/O base, decoded only within 0x100..0xff8, reset 0x3f0.
// - Interrupt select low nibble names the controller's interrupt line; reset 0x06.
// - DMA select codes 0..3 pick channel, 1xx disables; reset 0x02.
//
// Design decision made here: the Avalon-MM interface to the registers.
module fdcrb_bank
    import fdcrb_pkg::*;
#(
    parameter int DEBOUNCE_CYCLES = 16
) (
    input  wire logic                  clk_sys_i,          // System clock
    input  wire logic                  nrst_i,             // Sync reset, active low
    input  wire logic [ADDR_W-1:0]     avs_address_i,      // Byte address
    input  wire logic                  avs_read_i,         // Read request
    input  wire logic                  avs_write_i,        // Write request
    input  wire logic [DATA_W-1:0]     avs_writedata_i,    // Write data
    input  wire logic [DATA_W/8-1:0]   avs_byteenable_i,   // Byte lanes
    output logic [DATA_W-1:0]          avs_readdata_o,     // Read data
    output logic                       avs_waitrequest_o,  // Stall
    input  wire logic [NUM_PINS-1:0]   general_pin_i,      // Pins 25,26,27
    output logic [NUM_PINS-1:0]        pin_event_o,        // Conditioned triggers
    input  wire logic [IO_ADDR_W-1:0]  io_addr_i,          // Host I/O address
    input  wire logic                  io_cycle_i,         // Host I/O cycle valid
    output logic                       io_hit_o,           // Cycle claimed
    output logic [BASE_ALIGN-1:0]      io_offset_o,        // Port within block
    input  wire logic                  floppy_irq_i,       // Controller interrupt
    input  wire logic                  floppy_drq_i,       // Controller DMA request
    output logic [NUM_IRQ-1:0]         irq_line_o,         // Routed interrupt
    output logic [NUM_DMA-1:0]         drq_line_o,         // Routed DMA request
    output fdcrb_res_t                 floppy_res_o        // Resource view
);

    localparam int CNT_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYCLES - 1);

    // ************************************************************
    // Register file
    // ************************************************************
    logic [REG_W-1:0] pin_ctrl_r,  pin_ctrl_nxt;
    logic [REG_W-1:0] test_a_r,    test_a_nxt;
    logic [REG_W-1:0] test_b_r,    test_b_nxt;
    logic [REG_W-1:0] activate_r,  activate_nxt;
    logic [REG_W-1:0] base_hi_r,   base_hi_nxt;
    logic [REG_W-1:0] base_lo_r,   base_lo_nxt;
    logic [REG_W-1:0] irq_sel_r,   irq_sel_nxt;
    logic [REG_W-1:0] dma_sel_r,   dma_sel_nxt;
    logic             ack_r,       ack_nxt;
    logic [DATA_W-1:0] rdata_r,    rdata_nxt;

    logic             req;
    logic             wr_go;
    logic [7:0]       idx;
    logic [REG_W-1:0] wbyte;

    function automatic logic [REG_W-1:0] merge(input logic [REG_W-1:0] old_v,
                                               input logic [REG_W-1:0] new_v,
                                               input logic [REG_W-1:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    assign req   = avs_read_i | avs_write_i;
    assign idx   = 8'(avs_address_i[ADDR_W-1:IDX_LSB]);
    assign wbyte = avs_writedata_i[REG_W-1:0];
    assign wr_go = avs_write_i & ack_r & avs_byteenable_i[0];
    // One wait cycle so read data comes from a flop
    assign avs_waitrequest_o = req & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    always_comb begin
        pin_ctrl_nxt = pin_ctrl_r;
        test_a_nxt   = test_a_r;
        test_b_nxt   = test_b_r;
        activate_nxt = activate_r;
        base_hi_nxt  = base_hi_r;
        base_lo_nxt  = base_lo_r;
        irq_sel_nxt  = irq_sel_r;
        dma_sel_nxt  = dma_sel_r;
        ack_nxt      = req & ~ack_r;
        rdata_nxt    = rdata_r;
        if (wr_go) begin
            unique case (idx)
                IDX_PIN_CTRL:  pin_ctrl_nxt = merge(pin_ctrl_r, wbyte, MASK_PIN_CTRL);
                IDX_TEST_A:    test_a_nxt   = wbyte;
                IDX_TEST_B:    test_b_nxt   = wbyte;
                IDX_ACTIVATE:  activate_nxt = merge(activate_r, wbyte, MASK_ACTIVATE);
                IDX_BASE_HIGH: base_hi_nxt  = wbyte;
                IDX_BASE_LOW:  base_lo_nxt  = {wbyte[REG_W-1:BASE_ALIGN],
                                               BASE_ALIGN'(0)};
                IDX_IRQ_SEL:   irq_sel_nxt  = merge(irq_sel_r, wbyte, MASK_IRQ_SEL);
                IDX_DMA_SEL:   dma_sel_nxt  = merge(dma_sel_r, wbyte, MASK_DMA_SEL);
                default:       ;
            endcase
        end
        if (avs_read_i & ~ack_r) begin
            unique case (idx)
                IDX_PIN_CTRL:  rdata_nxt = DATA_W'(pin_ctrl_r);
                IDX_TEST_A:    rdata_nxt = DATA_W'(test_a_r);
                IDX_TEST_B:    rdata_nxt = DATA_W'(test_b_r);
                IDX_ACTIVATE:  rdata_nxt = DATA_W'(activate_r);
                IDX_BASE_HIGH: rdata_nxt = DATA_W'(base_hi_r);
                IDX_BASE_LOW:  rdata_nxt = DATA_W'(base_lo_r);
                IDX_IRQ_SEL:   rdata_nxt = DATA_W'(irq_sel_r);
                IDX_DMA_SEL:   rdata_nxt = DATA_W'(dma_sel_r);
                default:       rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            pin_ctrl_r <= RST_PIN_CTRL;
            test_a_r   <= RST_TEST;
            test_b_r   <= RST_TEST;
            activate_r <= RST_ACTIVATE;
            base_hi_r  <= RST_BASE_HIGH;
            base_lo_r  <= RST_BASE_LOW;
            irq_sel_r  <= RST_IRQ_SEL;
            dma_sel_r  <= RST_DMA_SEL;
            ack_r      <= 1'b0;
            rdata_r    <= '0;
        end else begin
            pin_ctrl_r <= pin_ctrl_nxt;
            test_a_r   <= test_a_nxt;
            test_b_r   <= test_b_nxt;
            activate_r <= activate_nxt;
            base_hi_r  <= base_hi_nxt;
            base_lo_r  <= base_lo_nxt;
            irq_sel_r  <= irq_sel_nxt;
            dma_sel_r  <= dma_sel_nxt;
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    // ************************************************************
    // Pin conditioning
    // ************************************************************
    logic [NUM_PINS-1:0] s1_r, s2_r, s3_r;
    logic [NUM_PINS-1:0] s1_nxt, s2_nxt, s3_nxt;
    logic [NUM_PINS-1:0] stable_r, stable_nxt;
    logic [NUM_PINS-1:0] deb_r, deb_nxt;
    logic [NUM_PINS-1:0] prev_r, prev_nxt;
    logic [NUM_PINS-1:0] event_r, event_nxt;
    logic [CNT_W-1:0]    cnt_r [NUM_PINS];
    logic [CNT_W-1:0]    cnt_nxt [NUM_PINS];
    logic [NUM_PINS-1:0] bypass;
    logic [NUM_PINS-1:0] level_mode;
    logic [NUM_PINS-1:0] cond;

    // Pin 26 has no bypass control, so its filter always stays in
    assign bypass     = {pin_ctrl_r[BIT_BYP_27], 1'b0, pin_ctrl_r[BIT_BYP_25]};
    assign level_mode = {pin_ctrl_r[BIT_TRIG_27],
                         pin_ctrl_r[BIT_TRIG_26],
                         pin_ctrl_r[BIT_TRIG_25]};

    always_comb begin
        s1_nxt     = general_pin_i;
        s2_nxt     = s1_r;
        s3_nxt     = s2_r;
        stable_nxt = stable_r;
        deb_nxt    = deb_r;
        for (int i = 0; i < NUM_PINS; i++) begin
            cnt_nxt[i] = '0;
            if (s2_r[i] == s3_r[i]) begin
                stable_nxt[i] = s3_r[i];
            end
            // Filter needs the level to hold a full window before it moves
            if (stable_r[i] != deb_r[i]) begin
                if (cnt_r[i] == CNT_LAST) begin
                    deb_nxt[i] = stable_r[i];
                end else begin
                    cnt_nxt[i] = cnt_r[i] + CNT_W'(1);
                end
            end
            cond[i] = bypass[i] ? stable_r[i] : deb_r[i];
        end
        prev_nxt  = cond;
        event_nxt = (level_mode & cond) | (~level_mode & cond & ~prev_r);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            stable_r <= '0;
            deb_r    <= '0;
            prev_r   <= '0;
            event_r  <= '0;
            for (int i = 0; i < NUM_PINS; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            s1_r     <= s1_nxt;
            s2_r     <= s2_nxt;
            s3_r     <= s3_nxt;
            stable_r <= stable_nxt;
            deb_r    <= deb_nxt;
            prev_r   <= prev_nxt;
            event_r  <= event_nxt;
            for (int i = 0; i < NUM_PINS; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    assign pin_event_o = event_r;

    // ************************************************************
    // Floppy resource routing
    // ************************************************************
    logic [15:0]         base;
    logic                base_ok;
    logic                active;
    logic                hit_r, hit_nxt;
    logic [BASE_ALIGN-1:0] off_r, off_nxt;
    logic [NUM_IRQ-1:0]  irq_r, irq_nxt;
    logic [NUM_DMA-1:0]  drq_r, drq_nxt;

    assign base    = {base_hi_r, base_lo_r};
    assign active  = activate_r[0];
    // Out-of-window base leaves the device unreachable rather than aliasing
    assign base_ok = (base >= BASE_MIN) && (base <= BASE_MAX);

    always_comb begin
        hit_nxt = active & base_ok & io_cycle_i
                & (io_addr_i[IO_ADDR_W-1:BASE_ALIGN]
                   == base[IO_ADDR_W-1:BASE_ALIGN]);
        off_nxt = io_addr_i[BASE_ALIGN-1:0];
        irq_nxt = '0;
        drq_nxt = '0;
        if (active & floppy_irq_i) begin
            irq_nxt[irq_sel_r[3:0]] = 1'b1;
        end
        if (active & floppy_drq_i & ~dma_sel_r[BIT_DMA_OFF]) begin
            drq_nxt[dma_sel_r[1:0]] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            hit_r <= 1'b0;
            off_r <= '0;
            irq_r <= '0;
            drq_r <= '0;
        end else begin
            hit_r <= hit_nxt;
            off_r <= off_nxt;
            irq_r <= irq_nxt;
            drq_r <= drq_nxt;
        end
    end

    assign io_hit_o     = hit_r;
    assign io_offset_o  = off_r;
    assign irq_line_o   = irq_r;
    assign drq_line_o   = drq_r;
    assign floppy_res_o = '{active: active, base: base,
                            irq: irq_sel_r[3:0], dma: dma_sel_r[2:0]};

endmodule

// ===== common/fdcrb_pkg.sv
// Purpose: Constants and types for the floppy resource configuration bank
// Assumes: Registers are one aligned Avalon word each, byte address = index * 4
// Notes:   Register data sits in bits 7:0, upper bits read as zero
package fdcrb_pkg;

    // ************************************************************
    // Register indices and bus geometry
    // ************************************************************
    localparam int          ADDR_W         = 10;
    localparam int          DATA_W         = 32;
    localparam int          REG_W          = 8;
    localparam logic [7:0]  IDX_PIN_CTRL   = 8'h2d;
    localparam logic [7:0]  IDX_TEST_A     = 8'h2e;
    localparam logic [7:0]  IDX_TEST_B     = 8'h2f;
    localparam logic [7:0]  IDX_ACTIVATE   = 8'h30;
    localparam logic [7:0]  IDX_BASE_HIGH  = 8'h60;
    localparam logic [7:0]  IDX_BASE_LOW   = 8'h61;
    localparam logic [7:0]  IDX_IRQ_SEL    = 8'h70;
    localparam logic [7:0]  IDX_DMA_SEL    = 8'h74;
    localparam int          IDX_LSB        = 2;

    // ************************************************************
    // Reset values and writable masks
    // ************************************************************
    localparam logic [7:0]  RST_PIN_CTRL   = 8'h00;
    localparam logic [7:0]  RST_TEST       = 8'h00;
    localparam logic [7:0]  RST_ACTIVATE   = 8'h01;
    localparam logic [7:0]  RST_BASE_HIGH  = 8'h03;
    localparam logic [7:0]  RST_BASE_LOW   = 8'hf0;
    localparam logic [7:0]  RST_IRQ_SEL    = 8'h06;
    localparam logic [7:0]  RST_DMA_SEL    = 8'h02;
    localparam logic [7:0]  MASK_PIN_CTRL  = 8'h57;
    localparam logic [7:0]  MASK_ACTIVATE  = 8'h01;
    localparam logic [7:0]  MASK_IRQ_SEL   = 8'h0f;
    localparam logic [7:0]  MASK_DMA_SEL   = 8'h07;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int          BIT_TRIG_25    = 0;
    localparam int          BIT_TRIG_26    = 1;
    localparam int          BIT_TRIG_27    = 2;
    localparam int          BIT_BYP_25     = 4;
    localparam int          BIT_BYP_27     = 6;
    localparam int          BIT_DMA_OFF    = 2;

    // ************************************************************
    // Base address window, pin and line counts
    // ************************************************************
    localparam int          IO_ADDR_W      = 12;
    localparam logic [15:0] BASE_MIN       = 16'h0100;
    localparam logic [15:0] BASE_MAX       = 16'h0ff8;
    localparam int          BASE_ALIGN     = 3;
    localparam int          NUM_PINS       = 3;
    localparam int          NUM_IRQ        = 16;
    localparam int          NUM_DMA        = 4;

    typedef struct packed {
        logic        active;
        logic [15:0] base;
        logic [3:0]  irq;
        logic [2:0]  dma;
    } fdcrb_res_t;

endpackage

// ===== tb/fdcrb_bank_assertions.sv
// Purpose: Port-level checks on the configuration bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every bank instance
module fdcrb_bank_assertions
    import fdcrb_pkg::*;
(
    input wire logic                 clk_sys_i,         // Clock
    input wire logic                 nrst_i,            // Reset, active low
    input wire logic [ADDR_W-1:0]    avs_address_i,     // Byte address
    input wire logic                 avs_read_i,        // Read
    input wire logic                 avs_write_i,       // Write
    input wire logic [DATA_W-1:0]    avs_writedata_i,   // Write data
    input wire logic [DATA_W/8-1:0]  avs_byteenable_i,  // Lanes
    input wire logic                 avs_waitrequest_o, // Stall
    input wire logic [IO_ADDR_W-1:0] io_addr_i,         // Host address
    input wire logic                 io_cycle_i,        // Host cycle
    input wire logic                 io_hit_o,          // Claim
    input wire logic                 floppy_irq_i,      // Controller irq
    input wire logic                 floppy_drq_i,      // Controller drq
    input wire logic [NUM_IRQ-1:0]   irq_line_o,        // Routed irq
    input wire logic [NUM_DMA-1:0]   drq_line_o,        // Routed drq
    input fdcrb_res_t                floppy_res_o       // Resources
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Helpers and properties
    // ************************************************************
    logic req;
    logic wr_act;
    logic hit_exp;
    assign req = avs_read_i | avs_write_i;
    assign wr_act = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0]
                  & (avs_address_i[9:2] == IDX_ACTIVATE);
    // Out-of-window base is stored but must never claim a cycle
    assign hit_exp = io_cycle_i & floppy_res_o.active & (floppy_res_o.base >= BASE_MIN)
                   & (floppy_res_o.base <= BASE_MAX)
                   & (io_addr_i[11:3] == floppy_res_o.base[11:3]);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    property p_one_wait; $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
    property p_act_wr; wr_act |=> floppy_res_o.active == $past(avs_writedata_i[0]); endproperty
    a_act_wr: assert property (p_act_wr) else $error("activate bit not stored");
    property p_base_al; floppy_res_o.base[2:0] == 3'h0; endproperty
    a_base_al: assert property (p_base_al) else $error("base not aligned");
    property p_hit; hit_exp |=> io_hit_o; endproperty
    a_hit: assert property (p_hit) else $error("decode missed");
    property p_idle; !floppy_res_o.active |=> !io_hit_o && irq_line_o == 16'h0
        && drq_line_o == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("inactive device drives");
    property p_irq; floppy_irq_i && floppy_res_o.active
        |=> irq_line_o == 16'h1 << $past(floppy_res_o.irq); endproperty
    a_irq: assert property (p_irq) else $error("irq routing wrong");
    property p_drq; floppy_drq_i && floppy_res_o.active && !floppy_res_o.dma[2]
        |=> drq_line_o == 4'h1 << $past(floppy_res_o.dma[1:0]); endproperty
    a_drq: assert property (p_drq) else $error("dma routing wrong");
    property p_dma_off; floppy_res_o.dma[2] |=> drq_line_o == 4'h0; endproperty
    a_dma_off: assert property (p_dma_off) else $error("dma not disabled");
    c_wr: cover property (wr_act);
    c_hit: cover property (io_hit_o);
    c_drq: cover property (drq_line_o != 4'h0);
endmodule

bind fdcrb_bank fdcrb_bank_assertions i_fdcrb_bank_assertions (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_waitrequest_o(avs_waitrequest_o),
    .io_addr_i(io_addr_i), .io_cycle_i(io_cycle_i), .io_hit_o(io_hit_o),
    .floppy_irq_i(floppy_irq_i), .floppy_drq_i(floppy_drq_i), .irq_line_o(irq_line_o),
    .drq_line_o(drq_line_o), .floppy_res_o(floppy_res_o));

// ===== tb/fdcrb_bank_tb_top.sv
// Purpose: Self-checking bench for the configuration bank
// Assumes: Short debounce count for run time
// Notes:   Pin timing checked relative between paths
module fdcrb_bank_tb_top
    import fdcrb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Signals and tables
    // ************************************************************
    localparam int         DEB = 2;
    logic                  clk_sys_i = 1'b0;
    logic                  nrst_i = 1'b0;
    logic [ADDR_W-1:0]     avs_address_i = '0;
    logic                  avs_read_i = 1'b0;
    logic                  avs_write_i = 1'b0;
    logic [DATA_W-1:0]     avs_writedata_i = '0;
    logic [DATA_W/8-1:0]   avs_byteenable_i = 4'hf;
    logic [DATA_W-1:0]     avs_readdata_o;
    logic                  avs_waitrequest_o;
    logic [NUM_PINS-1:0]   general_pin_i = '0;
    logic [NUM_PINS-1:0]   pin_event_o;
    logic [IO_ADDR_W-1:0]  io_addr_i = '0;
    logic                  io_cycle_i = 1'b0;
    logic                  io_hit_o;
    logic [BASE_ALIGN-1:0] io_offset_o;
    logic                  floppy_irq_i = 1'b1;
    logic                  floppy_drq_i = 1'b1;
    logic [NUM_IRQ-1:0]    irq_line_o;
    logic [NUM_DMA-1:0]    drq_line_o;
    fdcrb_res_t            floppy_res_o;
    int                    n_fail = 0;
    int                    checks = 0;
    int                    lat[3];
    int                    cnt[3];
    logic [DATA_W-1:0]     q;
    logic [7:0]            idx_t[8] = '{IDX_PIN_CTRL, IDX_TEST_A, IDX_TEST_B, IDX_ACTIVATE,
                                        IDX_BASE_HIGH, IDX_BASE_LOW, IDX_IRQ_SEL, IDX_DMA_SEL};
    logic [7:0]            rst_t[8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'hf0, 8'h06, 8'h02};
    logic [7:0]            ff_t[8] = '{8'h57, 8'hff, 8'hff, 8'h01, 8'hff, 8'hf8, 8'h0f, 8'h07};

    always #2.5 clk_sys_i = ~clk_sys_i;

    fdcrb_bank #(.DEBOUNCE_CYCLES(DEB)) i_fdcrb_bank (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .general_pin_i(general_pin_i),
        .pin_event_o(pin_event_o), .io_addr_i(io_addr_i), .io_cycle_i(io_cycle_i),
        .io_hit_o(io_hit_o), .io_offset_o(io_offset_o), .floppy_irq_i(floppy_irq_i),
        .floppy_drq_i(floppy_drq_i), .irq_line_o(irq_line_o), .drq_line_o(drq_line_o),
        .floppy_res_o(floppy_res_o));

    // ************************************************************
    // Tasks
    // ************************************************************
    task test_done;
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
        int k;
        @(posedge clk_sys_i);
        avs_address_i <= {i, 2'b00};
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= {24'h0, d};
        k = 0;
        #1;
        while (avs_waitrequest_o !== 1'b0 && k < 50) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        if (k == 50) begin
            n_fail++;
            test_done;
        end
        @(posedge clk_sys_i);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    // Latency and pulse count of each pin after a rise
    task pins(input logic [7:0] c);
        acc(1'b1, IDX_PIN_CTRL, c);
        general_pin_i <= 3'h0;
        repeat (12) @(posedge clk_sys_i);
        general_pin_i <= 3'h7;
        lat = '{-1, -1, -1};
        cnt = '{0, 0, 0};
        for (int t = 0; t < 30; t++) begin
            @(posedge clk_sys_i);
            #1;
            for (int p = 0; p < 3; p++) begin
                if (pin_event_o[p] === 1'b1) cnt[p]++;
                if (pin_event_o[p] === 1'b1 && lat[p] < 0) lat[p] = t;
            end
        end
    endtask

    task io(input logic [11:0] a, input logic h);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_cycle_i <= 1'b1;
        @(posedge clk_sys_i);
        io_cycle_i <= 1'b0;
        #1;
        chk("io_hit", io_hit_o, h);
    endtask

    task route;
        @(posedge clk_sys_i);
        #1;
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, idx_t[i], 8'h00);
            chk("reset", q, rst_t[i]);
            acc(1'b1, idx_t[i], 8'hff);
            acc(1'b0, idx_t[i], 8'h00);
            chk("mask", q, ff_t[i]);
        end
        acc(1'b1, 8'h31, 8'hff);
        acc(1'b0, 8'h31, 8'h00);
        chk("unmapped", q, 8'h00);
        for (int i = 0; i < 8; i++) acc(1'b1, idx_t[i], rst_t[i]);
        avs_byteenable_i <= 4'he;
        acc(1'b1, IDX_TEST_A, 8'h5a);
        avs_byteenable_i <= 4'hf;
        acc(1'b0, IDX_TEST_A, 8'h00);
        chk("lane", q, 8'h00);
        pins(8'h57);
        chk("byp25", 32'(lat[1] - lat[0]), DEB);
        chk("byp27", lat[2], lat[0]);
        pins(8'h07);
        chk("flt25", lat[0], lat[1]);
        chk("flt27", lat[2], lat[1]);
        chk("seen", 32'(lat[1] > 0), 32'h1);
        for (int b = 0; b < 3; b++) begin
            pins(8'h50 | (8'h01 << b));
            for (int p = 0; p < 3; p++)
                chk("trig", (p == b) ? 32'(cnt[p] > 1) : 32'(cnt[p]), 32'h1);
        end
        io(12'h3f5, 1'b1);
        chk("offset", io_offset_o, 3'h5);
        io(12'h3e8, 1'b0);
        for (int i = 0; i < 16; i++) begin
            acc(1'b1, IDX_IRQ_SEL, 8'(i));
            route;
            chk("irq", irq_line_o, 16'h1 << i);
        end
        for (int d = 0; d < 8; d++) begin
            acc(1'b1, IDX_DMA_SEL, 8'(d));
            route;
            chk("drq", drq_line_o, (d < 4) ? (4'h1 << d) : 4'h0);
        end
        acc(1'b1, IDX_DMA_SEL, 8'h00);
        floppy_irq_i <= 1'b0;
        floppy_drq_i <= 1'b0;
        route;
        route;
        chk("quiet", {irq_line_o, drq_line_o}, 20'h0);
        @(posedge clk_sys_i);
        floppy_irq_i <= 1'b1;
        floppy_drq_i <= 1'b1;
        acc(1'b1, IDX_ACTIVATE, 8'h00);
        route;
        chk("idle", {irq_line_o, drq_line_o}, 20'h0);
        io(12'h3f5, 1'b0);
        acc(1'b1, IDX_ACTIVATE, 8'h01);
        acc(1'b1, IDX_BASE_HIGH, 8'h00);
        acc(1'b1, IDX_BASE_LOW, 8'h80);
        io(12'h080, 1'b0);
        acc(1'b1, IDX_BASE_HIGH, 8'h0f);
        acc(1'b1, IDX_BASE_LOW, 8'hff);
        io(12'hffc, 1'b1);
        chk("base", floppy_res_o.base, 16'h0ff8);
        test_done;
    end
endmodule
